/* pof_pkg.sv */
// Constants, field layout and key states for the protected oscillator and filter registers.
// Assumes a 32-bit APB slave with a 12-bit byte address.
`default_nettype none

package pof_pkg;

    // ==========================================================
    // Register indices and byte addresses
    localparam logic [9:0] IDX_OSC = 10'h022;
    localparam logic [9:0] IDX_RST = 10'h024;
    localparam logic [9:0] IDX_VD = 10'h026;
    localparam logic [11:0] ADDR_OSC = {IDX_OSC, 2'b00};
    localparam logic [11:0] ADDR_RST = {IDX_RST, 2'b00};
    localparam logic [11:0] ADDR_VD = {IDX_VD, 2'b00};

    // ==========================================================
    // Field positions
    localparam int OSC_KEY_LSB = 14;
    localparam int RST_KEY_LSB = 14;
    localparam int VD_KEY_LSB = 28;
    localparam int VD_EN_BIT = 31;
    localparam int VD_VAL_LSB = 16;

    // ==========================================================
    // Values after reset
    localparam logic [9:0] OSC_DEFAULT = 10'h3ff;
    localparam logic [7:0] RST_DEFAULT = 8'hff;
    localparam logic [7:0] VD_VAL_DEFAULT = 8'h00;
    localparam logic VD_EN_DEFAULT = 1'b0;
    localparam logic [9:0] OSC_COUNT_RESET = 10'h000;

    // ==========================================================
    // Key sequence values
    localparam logic [1:0] KEY_LOCK = 2'b00;
    localparam logic [1:0] KEY_STEP1 = 2'b01;
    localparam logic [1:0] KEY_STEP2 = 2'b10;
    localparam logic [1:0] KEY_OPEN = 2'b11;

    typedef enum logic [1:0] {
        KS_IDLE,
        KS_GOT1,
        KS_GOT2,
        KS_OPEN
    } pof_key_state_e;

    function automatic logic [1:0] pof_key_field(input logic [31:0] d, input int lsb);
        return d[lsb +: 2];
    endfunction

endpackage : pof_pkg

`default_nettype wire

/* pof_unlock.sv */
// Two-bit write-enable key field with the 01, 10, 11 sequence.
// Assumes wr is a one-cycle strobe that marks a completed write to the owning register.
`default_nettype none

module pof_unlock (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic [1:0] key_in,
    output logic [1:0] key_read,
    output logic unlocked
);

    pof_pkg::pof_key_state_e state;

    // ==========================================================
    // Key sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pof_pkg::KS_IDLE;
        end else if (wr) begin
            unique case (state)
                pof_pkg::KS_IDLE: begin
                    state <= (key_in == pof_pkg::KEY_STEP1) ? pof_pkg::KS_GOT1 : pof_pkg::KS_IDLE;
                end
                pof_pkg::KS_GOT1: begin
                    if (key_in == pof_pkg::KEY_STEP2) begin
                        state <= pof_pkg::KS_GOT2;
                    end else if (key_in == pof_pkg::KEY_STEP1) begin
                        state <= pof_pkg::KS_GOT1;
                    end else begin
                        state <= pof_pkg::KS_IDLE;
                    end
                end
                pof_pkg::KS_GOT2: begin
                    if (key_in == pof_pkg::KEY_OPEN) begin
                        state <= pof_pkg::KS_OPEN;
                    end else if (key_in == pof_pkg::KEY_STEP1) begin
                        state <= pof_pkg::KS_GOT1;
                    end else begin
                        state <= pof_pkg::KS_IDLE;
                    end
                end
                pof_pkg::KS_OPEN: begin
                    // Only 00 relocks; anything else keeps it open
                    if (key_in == pof_pkg::KEY_LOCK) begin
                        state <= pof_pkg::KS_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        unique case (state)
            pof_pkg::KS_IDLE: key_read = pof_pkg::KEY_LOCK;
            pof_pkg::KS_GOT1: key_read = pof_pkg::KEY_STEP1;
            pof_pkg::KS_GOT2: key_read = pof_pkg::KEY_STEP2;
            pof_pkg::KS_OPEN: key_read = pof_pkg::KEY_OPEN;
        endcase
    end

    assign unlocked = (state == pof_pkg::KS_OPEN);

endmodule : pof_unlock

`default_nettype wire

/* pof_config_regs.sv */
// Protected oscillator stable-time and filter configuration registers on APB.
// Assumes customer-area inputs are stable when power-on reset is released and
// lf_tick is a one-pclk pulse per 128 kHz oscillator cycle.
//
// Notes on behaviour
// - Stable-time writes are ignored until the key field has seen 01, then 10, then 11.
// - With the key field at 11 every write to the protected bits is accepted.
// - A key field at 11 clears only on a write of 00, which locks the register.
// - A key field at 11 ignores any non-zero write and keeps reading 11.
// - The ten-bit stable time loads from the customer area at power-on if enabled, else all ones.
// - Once the oscillator is enabled, the programmed number of 128 kHz cycles pass before its clock goes on.
// - The reset-pin filter register is guarded by its own key field with the same sequence.
// - The reset-pin filter value takes its power-on value from the customer area when enabled.
// - The voltage-detector filter register has its own key field with the same sequence.
// - Bit 31 of the voltage-detector filter register turns the filter on when 1 and off when 0.
// - With the filter enable set at power-on, the filter value in bits 23:16 loads from the customer area.
// - Reserved bits of the voltage-detector filter register read zero and writes to them end without error.
// - A separate enable flag decides whether the stable time is loaded at power-on.
//
// The APB slave port was chosen for this implementation.
`default_nettype none

module pof_config_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_time_load_enable,
    input wire logic [9:0] cia_osc_stable_count,
    input wire logic cia_reset_filter_load_enable,
    input wire logic [7:0] cia_reset_filter_value,
    input wire logic cia_vd_filter_enable,
    input wire logic [7:0] cia_vd_filter_value,
    input wire logic osc_enable,
    input wire logic lf_tick,
    output logic [9:0] internal_osc_stable_count,
    output logic [7:0] reset_pin_filter_value,
    output logic voltage_detector_filter_enable,
    output logic [7:0] voltage_detector_filter_value,
    output logic osc_clock_pass,
    output logic por_load_done
);

    // ==========================================================
    // Bus decode
    logic access;
    logic wr_access;
    logic sel_osc;
    logic sel_rst;
    logic sel_vd;
    logic mapped;
    logic wr_osc;
    logic wr_rst;
    logic wr_vd;
    logic [31:0] next_prdata;

    assign access = psel && penable && pready;
    // Writes before the power-on load has landed would be overwritten, so refuse them
    assign wr_access = access && pwrite && por_load_done;
    assign sel_osc = (paddr == pof_pkg::ADDR_OSC);
    assign sel_rst = (paddr == pof_pkg::ADDR_RST);
    assign sel_vd = (paddr == pof_pkg::ADDR_VD);
    assign mapped = sel_osc || sel_rst || sel_vd;
    assign wr_osc = wr_access && sel_osc;
    assign wr_rst = wr_access && sel_rst;
    assign wr_vd = wr_access && sel_vd;

    // ==========================================================
    // Key fields
    logic [1:0] osc_key;
    logic [1:0] rst_key;
    logic [1:0] vd_key;
    logic osc_open;
    logic rst_open;
    logic vd_open;

    pof_unlock u_osc_key (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_osc),
        .key_in(pof_pkg::pof_key_field(pwdata, pof_pkg::OSC_KEY_LSB)),
        .key_read(osc_key),
        .unlocked(osc_open)
    );

    pof_unlock u_rst_key (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_rst),
        .key_in(pof_pkg::pof_key_field(pwdata, pof_pkg::RST_KEY_LSB)),
        .key_read(rst_key),
        .unlocked(rst_open)
    );

    pof_unlock u_vd_key (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_vd),
        .key_in(pof_pkg::pof_key_field(pwdata, pof_pkg::VD_KEY_LSB)),
        .key_read(vd_key),
        .unlocked(vd_open)
    );

    // ==========================================================
    // Power-on load
    // Straps are caught on the first edge after release, never by the reset itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_load_done <= 1'b0;
        end else begin
            por_load_done <= 1'b1;
        end
    end

    // ==========================================================
    // Oscillator stable time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_osc_stable_count <= pof_pkg::OSC_DEFAULT;
        end else if (!por_load_done) begin
            if (osc_time_load_enable) begin
                internal_osc_stable_count <= cia_osc_stable_count;
            end
        end else if (wr_osc && osc_open) begin
            // Lock state before this write decides; the write that opens it stores nothing
            internal_osc_stable_count <= pwdata[9:0];
        end
    end

    // ==========================================================
    // Reset-pin filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pin_filter_value <= pof_pkg::RST_DEFAULT;
        end else if (!por_load_done) begin
            if (cia_reset_filter_load_enable) begin
                reset_pin_filter_value <= cia_reset_filter_value;
            end
        end else if (wr_rst && rst_open) begin
            reset_pin_filter_value <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Voltage-detector filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voltage_detector_filter_enable <= pof_pkg::VD_EN_DEFAULT;
        end else if (!por_load_done) begin
            voltage_detector_filter_enable <= cia_vd_filter_enable;
        end else if (wr_vd && vd_open) begin
            voltage_detector_filter_enable <= pwdata[pof_pkg::VD_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voltage_detector_filter_value <= pof_pkg::VD_VAL_DEFAULT;
        end else if (!por_load_done) begin
            if (cia_vd_filter_enable) begin
                voltage_detector_filter_value <= cia_vd_filter_value;
            end
        end else if (wr_vd && vd_open) begin
            voltage_detector_filter_value <= pwdata[pof_pkg::VD_VAL_LSB +: 8];
        end
    end

    // ==========================================================
    // Oscillator start-up wait
    logic [9:0] lf_count;
    logic count_reached;

    // A programmed zero passes the clock one pclk after enable
    assign count_reached = (lf_count >= internal_osc_stable_count);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_count <= pof_pkg::OSC_COUNT_RESET;
        end else if (!osc_enable) begin
            lf_count <= pof_pkg::OSC_COUNT_RESET;
        end else if (!count_reached && lf_tick) begin
            lf_count <= lf_count + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_clock_pass <= 1'b0;
        end else if (!osc_enable) begin
            osc_clock_pass <= 1'b0;
        end else if (count_reached) begin
            // Lowering the count later never withdraws a running clock
            osc_clock_pass <= 1'b1;
        end
    end

    // ==========================================================
    // Read data
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (sel_osc) begin
            next_prdata[pof_pkg::OSC_KEY_LSB +: 2] = osc_key;
            next_prdata[9:0] = internal_osc_stable_count;
        end else if (sel_rst) begin
            next_prdata[pof_pkg::RST_KEY_LSB +: 2] = rst_key;
            next_prdata[7:0] = reset_pin_filter_value;
        end else if (sel_vd) begin
            // Everything else in this word stays zero
            next_prdata[pof_pkg::VD_EN_BIT] = voltage_detector_filter_enable;
            next_prdata[pof_pkg::VD_KEY_LSB +: 2] = vd_key;
            next_prdata[pof_pkg::VD_VAL_LSB +: 8] = voltage_detector_filter_value;
        end
    end

    // ==========================================================
    // APB answer
    // Data is captured in the setup cycle so the access phase ends with no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            // Mapped registers never error, even on writes to reserved or locked bits
            pslverr <= psel && !penable && !mapped;
        end
    end

endmodule : pof_config_regs

`default_nettype wire

/* pof_config_props.sv */
// Concurrent checks for the protected oscillator and filter register block.
// Assumes it is bound into pof_config_regs and sees only that module's ports.
`default_nettype none

module pof_config_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_time_load_enable,
    input wire logic [9:0] cia_osc_stable_count,
    input wire logic osc_enable,
    input wire logic [9:0] internal_osc_stable_count,
    input wire logic [7:0] reset_pin_filter_value,
    input wire logic osc_clock_pass,
    input wire logic por_load_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Transfer phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    logic mapped;
    assign mapped = paddr inside {pof_pkg::ADDR_OSC, pof_pkg::ADDR_RST, pof_pkg::ADDR_VD};

    // ==========================================================
    // Assertions
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("pready without transfer");
    a_unmapped_err: assert property (s_access ##0 !mapped |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_no_err: assert property (s_access ##0 mapped |-> !pslverr)
        else $error("error on mapped address");
    a_vd_reserved: assert property (s_access ##0 (!pwrite && paddr == pof_pkg::ADDR_VD)
        |-> (prdata & 32'h4f00ffff) == 32'h0)
        else $error("reserved bits not zero");
    a_osc_hold: assert property ($changed(internal_osc_stable_count)
        && $past(por_load_done)
        |-> $past(psel && penable && pready && pwrite && paddr == pof_pkg::ADDR_OSC))
        else $error("stable time changed without write");
    a_rst_hold: assert property ($changed(reset_pin_filter_value)
        && $past(por_load_done)
        |-> $past(psel && penable && pready && pwrite && paddr == pof_pkg::ADDR_RST))
        else $error("reset filter changed without write");
    a_pass_off: assert property (!osc_enable |=> !osc_clock_pass)
        else $error("clock passed while oscillator off");
    a_count_load: assert property ($rose(por_load_done)
        |-> internal_osc_stable_count ==
        (osc_time_load_enable ? cia_osc_stable_count : pof_pkg::OSC_DEFAULT))
        else $error("wrong stable time after power-on");
    a_por_stays: assert property (por_load_done |=> por_load_done)
        else $error("load done dropped");
endmodule // pof_config_props

bind pof_config_regs pof_config_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .osc_time_load_enable, .cia_osc_stable_count,
    .osc_enable, .internal_osc_stable_count, .reset_pin_filter_value, .osc_clock_pass,
    .por_load_done);

`default_nettype wire

/* tb.sv */
// Self-checking bench for pof_config_regs, driven as an APB master.
// Assumes a slave that answers after setup; the master still waits for pready.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic osc_time_load_enable, cia_reset_filter_load_enable, cia_vd_filter_enable;
    logic osc_enable, lf_tick, osc_clock_pass, por_load_done, voltage_detector_filter_enable;
    logic [9:0] cia_osc_stable_count, internal_osc_stable_count;
    logic [7:0] cia_reset_filter_value, cia_vd_filter_value, reset_pin_filter_value;
    logic [7:0] voltage_detector_filter_value;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h8fe7;
    logic [33:0] exp_q[$];
    logic [33:0] ent;
    logic [11:0] addr_t[3] = '{pof_pkg::ADDR_OSC, pof_pkg::ADDR_RST, pof_pkg::ADDR_VD};
    int lsb_t[3] = '{pof_pkg::OSC_KEY_LSB, pof_pkg::RST_KEY_LSB, pof_pkg::VD_KEY_LSB};
    logic [31:0] mask_t[3] = '{32'h3ff, 32'hff, 32'h80ff0000};
    logic [31:0] cur[3];

    pof_config_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .osc_time_load_enable, .cia_osc_stable_count,
        .cia_reset_filter_load_enable, .cia_reset_filter_value, .cia_vd_filter_enable,
        .cia_vd_filter_value, .osc_enable, .lf_tick, .internal_osc_stable_count,
        .reset_pin_filter_value, .voltage_detector_filter_enable,
        .voltage_detector_filter_value, .osc_clock_pass, .por_load_done);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] obs(input int r);
        if (r == 0) return {22'h0, internal_osc_stable_count};
        if (r == 1) return {24'h0, reset_pin_filter_value};
        return {voltage_detector_filter_enable, 7'h0, voltage_detector_filter_value, 16'h0};
    endfunction

    task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", name, e, g);
        end
    endtask

    // Request held until pready is seen; caller stands just after an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] ex, input logic er);
        int n;
        exp_q.push_back({wr, er, ex});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
    endtask

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wkey(input int r, input logic [1:0] k, input logic [31:0] v);
        apb(1'b1, addr_t[r], (v & ~(32'h3 << lsb_t[r])) | (32'(k) << lsb_t[r]), 32'h0, 1'b0);
    endtask

    task automatic rd(input int r, input logic [1:0] k);
        apb(1'b0, addr_t[r], 32'h0, cur[r] | (32'(k) << lsb_t[r]), 1'b0);
    endtask

    task automatic test_done();
        check_val("pending", 32'h0, 32'(exp_q.size()));
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Response watcher and timeout
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            test_done();
        end
        if (psel && penable && pready && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            check_val("pslverr", 32'(ent[32]), 32'(pslverr));
            if (!ent[33]) check_val("prdata", ent[31:0], prdata);
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        osc_enable = 1'b0;
        lf_tick = 1'b0;
        osc_time_load_enable = 1'b1;
        cia_reset_filter_load_enable = 1'b0;
        cia_vd_filter_enable = 1'b1;
        cia_osc_stable_count = 10'(rnd() >> 22);
        cia_reset_filter_value = 8'(rnd() >> 24);
        cia_vd_filter_value = 8'(rnd() >> 24);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // First write only after the power-on load has landed
        repeat (2) @(posedge pclk);
        check_val("load done", 32'h1, 32'(por_load_done));
        cur[0] = {22'h0, cia_osc_stable_count};
        cur[1] = 32'h000000ff;
        cur[2] = {1'b1, 7'h0, cia_vd_filter_value, 16'h0};
        for (int r = 0; r < 3; r++) begin
            check_val("power-on value", cur[r], obs(r));
            rd(r, 2'b00);
            wkey(r, 2'b00, rnd());
            wkey(r, 2'b01, rnd());
            wkey(r, 2'b11, rnd());
            rd(r, 2'b00);
            wkey(r, 2'b01, rnd());
            wkey(r, 2'b10, rnd());
            wkey(r, 2'b11, rnd());
            rd(r, 2'b11);
            d = rnd() | 32'h80000000;
            wkey(r, 2'b11, d);
            cur[r] = d & mask_t[r];
            d = rnd() & 32'h7fffffff;
            wkey(r, 2'b10, d);
            cur[r] = d & mask_t[r];
            rd(r, 2'b11);
            d = rnd();
            // Relock write still lands: the field read 11 when it was taken
            wkey(r, 2'b00, d);
            cur[r] = d & mask_t[r];
            wkey(r, 2'b01, rnd());
            rd(r, 2'b01);
            idle();
            check_val("register output", cur[r], obs(r));
        end
        apb(1'b0, 12'h08c, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h0a0, 32'hffffffff, 32'h0, 1'b1);
        // Short stable time so the wait is seen in a few ticks
        wkey(0, 2'b10, 32'h0);
        wkey(0, 2'b11, 32'h0);
        wkey(0, 2'b11, 32'h3);
        idle();
        osc_enable <= 1'b1;
        for (int t = 1; t <= 3; t++) begin
            lf_tick <= 1'b1;
            @(posedge pclk);
            lf_tick <= 1'b0;
            repeat (3) @(posedge pclk);
            check_val("clock pass", 32'(t == 3), 32'(osc_clock_pass));
        end
        osc_enable <= 1'b0;
        repeat (2) @(posedge pclk);
        check_val("clock pass", 32'h0, 32'(osc_clock_pass));
        // Second power-on with the load disabled
        presetn <= 1'b0;
        osc_time_load_enable <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check_val("stable default", 32'h3ff, obs(0));
        test_done();
    end
endmodule // tb

`default_nettype wire
